// >>> rtl/tle_tap_link.sv
// Function
// - tap starts when a selected axis magnitude rises above tap level
// - an excursion longer than the maximum duration is no tap
// - after first tap ends, wait the gap time before the window
// - second tap must begin inside the window; it may end later
// - single only: single event on fall below level within duration
// - single and double: single event once double is settled
// - spike cancel set: any above-level sample in gap kills double
// - above level when the window opens kills the double tap
// - second tap above level past the duration kills the double
// - tap events raised only for kinds enabled in event enable
// - each axis joins tap detection only when its select bit is set
// - double tap needs both gap time and window non-zero
// - on a tap event record the axis that first exceeded level
// - first axis status is never cleared, only overwritten
// - activity, free fall and tap use the raw sample stream
// - lower output rates come from decimating the sample rate
// - with link, activity is sought only after inactivity
// - no auto sleep while an activity event is uncleared
// - auto sleep flag in first axis status shows the sleep state
// - reading event source clears the event flags
`timescale 1ns/1ps
module tle_tap_link #(
  parameter int LVL_SHIFT = 4
)
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        smp_valid,
  input  wire logic [15:0] smp_x,
  input  wire logic [15:0] smp_y,
  input  wire logic [15:0] smp_z,
  output logic             odr_strobe,
  output logic             auto_sleep
);

  // level scaling beyond 8 places would push the byte out of the word
  if (LVL_SHIFT < 0 || LVL_SHIFT > 8)
  begin : g_chk
    $error("LVL_SHIFT must lie in 0..8");
  end

  tle_pkg::tle_st_t               q;
  tle_pkg::tle_st_t               d;
  logic [2:0][15:0]               smp;
  logic [2:0]                     tap_hit;
  logic [2:0]                     act_hit;
  logic [2:0]                     inact_low;
  logic [2:0]                     ff_low;
  logic [15:0]                    tlvl;
  logic [15:0]                    alvl;
  logic [15:0]                    ilvl;
  logic [15:0]                    flvl;
  logic                           above;
  logic                           dbl_on;
  logic                           acc;
  logic                           rd_src;
  logic                           tap_ev;
  logic                           inv;
  logic                           dbl_ok;
  logic                           det_act;
  logic                           det_inact;
  logic                           hit;
  logic [31:0]                    rdat;
  logic [tle_pkg::NEV-1:0]        ev_set;
  logic [tle_pkg::NEV-1:0]        ev_clr;

  function automatic logic [15:0] mag(input logic [15:0] v);
    mag = v[15] ? 16'(-v) : v;
  endfunction : mag

  // byte levels scaled onto the sample magnitude
  assign smp  = {smp_z, smp_y, smp_x};
  assign tlvl = 16'({8'h00, q.tap_level} << LVL_SHIFT);
  assign alvl = 16'({8'h00, q.act_lvl} << LVL_SHIFT);
  assign ilvl = 16'({8'h00, q.inact_lvl} << LVL_SHIFT);
  assign flvl = 16'({8'h00, q.ff_lvl} << LVL_SHIFT);

  // per-axis compares on the undecimated, unfiltered samples
  for (genvar g = 0; g < 3; g++)
  begin : g_axis
    assign tap_hit[g]   = q.axes[g] && (mag(smp[g]) > tlvl);
    assign act_hit[g]   = mag(smp[g]) > alvl;
    assign inact_low[g] = mag(smp[g]) < ilvl;
    assign ff_low[g]    = mag(smp[g]) < flvl;
  end

  assign above  = |tap_hit;
  assign dbl_on = q.ev_en[tle_pkg::EV_DOUBLE] && (q.gap != 8'h00)
                  && (q.win != 8'h00);
  assign acc    = psel & penable & q.pready;
  assign rd_src = acc & ~pwrite & (paddr == tle_pkg::OFF_EV_SRC);
  // only bits that went out on the bus are cleared, so a late set survives
  assign ev_clr = rd_src ? q.prdata[tle_pkg::NEV-1:0] : '0;

  // register read mux and address decode
  always_comb
  begin
    hit  = 1'b1;
    rdat = 32'h0000_0000;
    case (paddr)
      tle_pkg::OFF_TAP_LEVEL: rdat = 32'(q.tap_level);
      tle_pkg::OFF_MAX_DURATION: rdat = 32'(q.max_duration);
      tle_pkg::OFF_TAP_GAP:   rdat = 32'(q.gap);
      tle_pkg::OFF_TAP_WIN:   rdat = 32'(q.win);
      tle_pkg::OFF_TAP_AXES:  rdat = 32'(q.axes);
      tle_pkg::OFF_EV_EN:     rdat = 32'(q.ev_en);
      tle_pkg::OFF_EV_SRC:    rdat = 32'(q.ev_src);
      tle_pkg::OFF_FIRST:     rdat = 32'({q.auto_sleep_flag, q.first_axis});
      tle_pkg::OFF_ACT_LVL:   rdat = 32'(q.act_lvl);
      tle_pkg::OFF_INACT_LVL: rdat = 32'(q.inact_lvl);
      tle_pkg::OFF_FF_LVL:    rdat = 32'(q.ff_lvl);
      tle_pkg::OFF_DECIM:     rdat = 32'(q.decim);
      default:                hit  = 1'b0;
    endcase
  end

  // next state: bus, tap sequencer, activity link, decimator
  always_comb
  begin
    d         = q;
    ev_set    = '0;
    tap_ev    = 1'b0;
    inv       = 1'b0;
    dbl_ok    = 1'b0;
    det_act   = 1'b0;
    det_inact = 1'b0;
    d.odr     = 1'b0;
    // one wait state: pready rises in the second access cycle
    d.pready  = psel & penable & ~q.pready;
    d.prdata  = (d.pready & ~pwrite) ? rdat : 32'h0000_0000;
    d.pslverr = d.pready & ~hit;

    if (acc && pwrite)
    begin
      case (paddr)
        tle_pkg::OFF_TAP_LEVEL: d.tap_level = pwdata[7:0];
        tle_pkg::OFF_MAX_DURATION: d.max_duration = pwdata[7:0];
        tle_pkg::OFF_TAP_GAP:   d.gap       = pwdata[7:0];
        tle_pkg::OFF_TAP_WIN:   d.win       = pwdata[7:0];
        tle_pkg::OFF_TAP_AXES:  d.axes      = pwdata[3:0];
        tle_pkg::OFF_EV_EN:     d.ev_en     = pwdata[6:0];
        tle_pkg::OFF_ACT_LVL:   d.act_lvl   = pwdata[7:0];
        tle_pkg::OFF_INACT_LVL: d.inact_lvl = pwdata[7:0];
        tle_pkg::OFF_FF_LVL:    d.ff_lvl    = pwdata[7:0];
        tle_pkg::OFF_DECIM:     d.decim     = pwdata[7:0];
        default:                d.decim     = q.decim;
      endcase
    end

    if (smp_valid)
    begin
      // output rate is every (decim+1)-th sample of the common rate
      if (q.dcnt == q.decim)
      begin
        d.dcnt = 8'h00;
        d.odr  = 1'b1;
      end
      else
      begin
        d.dcnt = 8'(q.dcnt + 8'h01);
      end

      // tap sequencer; every count step is one sample period
      case (q.tst)
        tle_pkg::TS_IDLE:
        begin
          if (above)
          begin
            d.tst      = tle_pkg::TS_TAP1;
            d.tcnt     = 8'h01;
            d.tax_pend = tap_hit;
          end
        end
        tle_pkg::TS_TAP1:
        begin
          if (!above && dbl_on)
          begin
            d.tst  = tle_pkg::TS_GAP;
            d.tcnt = 8'h00;
          end
          else if (!above)
          begin
            d.tst  = tle_pkg::TS_IDLE;
            tap_ev = q.ev_en[tle_pkg::EV_SINGLE];
            ev_set[tle_pkg::EV_SINGLE] = q.ev_en[tle_pkg::EV_SINGLE];
          end
          else if (q.tcnt >= q.max_duration)
          begin
            d.tst = tle_pkg::TS_LOW;
          end
          else
          begin
            d.tcnt = 8'(q.tcnt + 8'h01);
          end
        end
        tle_pkg::TS_GAP:
        begin
          if (above && q.axes[tle_pkg::AX_SPIKE])
          begin
            inv = 1'b1;
          end
          else if (8'(q.tcnt + 8'h01) == q.gap)
          begin
            d.tst  = tle_pkg::TS_WIN;
            d.tcnt = 8'h00;
          end
          else
          begin
            d.tcnt = 8'(q.tcnt + 8'h01);
          end
        end
        tle_pkg::TS_WIN:
        begin
          if (above && q.tcnt == 8'h00)
          begin
            inv = 1'b1;
          end
          else if (above)
          begin
            d.tst  = tle_pkg::TS_TAP2;
            d.tcnt = 8'h01;
          end
          else if (8'(q.tcnt + 8'h01) == q.win)
          begin
            inv = 1'b1;
          end
          else
          begin
            d.tcnt = 8'(q.tcnt + 8'h01);
          end
        end
        tle_pkg::TS_TAP2:
        begin
          if (!above)
          begin
            dbl_ok = 1'b1;
          end
          else if (q.tcnt >= q.max_duration)
          begin
            inv = 1'b1;
          end
          else
          begin
            d.tcnt = 8'(q.tcnt + 8'h01);
          end
        end
        tle_pkg::TS_LOW:
        begin
          // rejected excursion must end before a new tap can start
          if (!above)
          begin
            d.tst = tle_pkg::TS_IDLE;
          end
        end
        default: d.tst = tle_pkg::TS_IDLE;
      endcase

      // a settled double attempt releases the delayed single event
      if (inv || dbl_ok)
      begin
        d.tst  = above ? tle_pkg::TS_LOW : tle_pkg::TS_IDLE;
        // double enable rechecked: software may drop it mid-attempt
        tap_ev = q.ev_en[tle_pkg::EV_SINGLE]
                 | (dbl_ok & q.ev_en[tle_pkg::EV_DOUBLE]);
        ev_set[tle_pkg::EV_SINGLE] = q.ev_en[tle_pkg::EV_SINGLE];
        ev_set[tle_pkg::EV_DOUBLE] = dbl_ok
                                     & q.ev_en[tle_pkg::EV_DOUBLE];
      end

      // activity and inactivity, alternating when linked
      det_act   = (|act_hit) && q.ev_en[tle_pkg::EV_ACT]
                  && (!q.ev_en[tle_pkg::EN_LINK] || q.act_armed);
      det_inact = (&inact_low) && q.ev_en[tle_pkg::EV_INACT]
                  && (!q.ev_en[tle_pkg::EN_LINK] || q.inact_armed);
      ev_set[tle_pkg::EV_ACT]   = det_act;
      ev_set[tle_pkg::EV_INACT] = det_inact;
      ev_set[tle_pkg::EV_FFALL] = (&ff_low) && q.ev_en[tle_pkg::EV_FFALL];
      if (det_act)
      begin
        d.act_armed   = 1'b0;
        d.inact_armed = 1'b1;
        d.auto_sleep_flag      = 1'b0;
      end
      else if (det_inact)
      begin
        d.act_armed   = 1'b1;
        d.inact_armed = 1'b0;
        // a pending activity flag holds the part awake
        if (q.ev_en[tle_pkg::EN_SLEEP] && q.ev_en[tle_pkg::EN_LINK]
            && !q.ev_src[tle_pkg::EV_ACT])
        begin
          d.auto_sleep_flag = 1'b1;
        end
      end
    end

    // overwritten on a tap event, never cleared
    if (tap_ev)
    begin
      d.first_axis = q.tax_pend;
    end
    d.ev_src = (q.ev_src & ~ev_clr) | ev_set;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      q <= '{tap_level:   tle_pkg::RST_LEVEL,
             max_duration: tle_pkg::RST_TIME,
             gap:         tle_pkg::RST_TIME,
             win:         tle_pkg::RST_TIME,
             axes:        tle_pkg::RST_AXES,
             ev_en:       tle_pkg::RST_EV_EN,
             act_lvl:     tle_pkg::RST_LEVEL,
             inact_lvl:   tle_pkg::RST_TIME,
             ff_lvl:      tle_pkg::RST_TIME,
             decim:       tle_pkg::RST_DECIM,
             tst:         tle_pkg::TS_IDLE,
             inact_armed: 1'b1,
             default:     '0};
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata     = q.prdata;
  assign pready     = q.pready;
  assign pslverr    = q.pslverr;
  assign odr_strobe = q.odr;
  assign auto_sleep = q.auto_sleep_flag;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // tap steps as sequences
  sequence s_step(tle_pkg::tle_tap_t st);
    smp_valid && q.tst == st;
  endsequence

  property p_start;
    s_step(tle_pkg::TS_IDLE) ##0 above |=> q.tst == tle_pkg::TS_TAP1;
  endproperty
  a_start: assert property (p_start)
    else $error("tap start missed");

  property p_long;
    s_step(tle_pkg::TS_TAP1) ##0 above && q.tcnt >= q.max_duration
      |=> q.tst == tle_pkg::TS_LOW && !$rose(q.ev_src[0]);
  endproperty
  a_long: assert property (p_long)
    else $error("long excursion accepted");

  property p_gap;
    s_step(tle_pkg::TS_GAP) ##0 !above ##0 8'(q.tcnt + 8'h01) == q.gap
      |=> q.tst == tle_pkg::TS_WIN && q.tcnt == 8'h00;
  endproperty
  a_gap: assert property (p_gap)
    else $error("window not opened after gap");

  property p_second;
    s_step(tle_pkg::TS_WIN) ##0 above && q.tcnt != 8'h00
      |=> q.tst == tle_pkg::TS_TAP2;
  endproperty
  a_second: assert property (p_second)
    else $error("second tap not taken");

  property p_single;
    s_step(tle_pkg::TS_TAP1) ##0 !above && !dbl_on
      && q.ev_en[tle_pkg::EV_SINGLE] |=> q.ev_src[tle_pkg::EV_SINGLE];
  endproperty
  a_single: assert property (p_single)
    else $error("single tap not raised");

  property p_delay;
    s_step(tle_pkg::TS_TAP1) ##0 !above && dbl_on
      |=> q.tst == tle_pkg::TS_GAP && !$rose(q.ev_src[0]);
  endproperty
  a_delay: assert property (p_delay)
    else $error("single not delayed");

  property p_spike;
    s_step(tle_pkg::TS_GAP) ##0 above && q.axes[tle_pkg::AX_SPIKE]
      |=> q.tst inside {tle_pkg::TS_LOW, tle_pkg::TS_IDLE};
  endproperty
  a_spike: assert property (p_spike)
    else $error("gap spike did not cancel");

  property p_open_high;
    s_step(tle_pkg::TS_WIN) ##0 above && q.tcnt == 8'h00
      |=> q.tst == tle_pkg::TS_LOW && !$rose(q.ev_src[1]);
  endproperty
  a_open_high: assert property (p_open_high)
    else $error("double not cancelled at window open");

  property p_dbl_cause;
    $rose(q.ev_src[tle_pkg::EV_DOUBLE]) |->
      $past(q.tst) == tle_pkg::TS_TAP2 && $past(dbl_on);
  endproperty
  a_dbl_cause: assert property (p_dbl_cause)
    else $error("double tap without cause");

  property p_first;
    q.first_axis != $past(q.first_axis) |-> $past(tap_ev);
  endproperty
  a_first: assert property (p_first)
    else $error("first axis changed without tap");

  property p_clear;
    rd_src && !ev_set[tle_pkg::EV_ACT] && q.prdata[tle_pkg::EV_ACT]
      |=> !q.ev_src[tle_pkg::EV_ACT];
  endproperty
  a_clear: assert property (p_clear)
    else $error("source read did not clear");

  property p_sleep;
    $rose(q.auto_sleep_flag) |-> !$past(q.ev_src[tle_pkg::EV_ACT]);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("slept with activity pending");

endmodule : tle_tap_link

// >>> rtl/tle_pkg.sv
package tle_pkg;

  // sample and bus widths, event count
  localparam int DW  = 16;
  localparam int AW  = 8;
  localparam int NEV = 5;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFF_TAP_LEVEL = 8'h00;
  localparam logic [7:0] OFF_MAX_DURATION = 8'h04;
  localparam logic [7:0] OFF_TAP_GAP   = 8'h08;
  localparam logic [7:0] OFF_TAP_WIN   = 8'h0C;
  localparam logic [7:0] OFF_TAP_AXES  = 8'h10;
  localparam logic [7:0] OFF_EV_EN     = 8'h14;
  localparam logic [7:0] OFF_EV_SRC    = 8'h18;
  localparam logic [7:0] OFF_FIRST     = 8'h1C;
  localparam logic [7:0] OFF_ACT_LVL   = 8'h20;
  localparam logic [7:0] OFF_INACT_LVL = 8'h24;
  localparam logic [7:0] OFF_FF_LVL    = 8'h28;
  localparam logic [7:0] OFF_DECIM     = 8'h2C;

  // event bit positions in source and enable registers
  localparam int EV_SINGLE = 0;
  localparam int EV_DOUBLE = 1;
  localparam int EV_ACT    = 2;
  localparam int EV_INACT  = 3;
  localparam int EV_FFALL  = 4;
  localparam int EN_LINK   = 5;
  localparam int EN_SLEEP  = 6;

  // axis select: bits 2:0 axes x,y,z, bit 3 gap spike cancel
  localparam int AX_SPIKE  = 3;
  // first axis status: bits 2:0 axes, bit 3 auto sleep flag
  localparam int FA_SLEEP  = 3;

  // reset values
  localparam logic [7:0] RST_LEVEL = 8'hFF;
  localparam logic [7:0] RST_TIME  = 8'h00;
  localparam logic [7:0] RST_DECIM = 8'h00;
  localparam logic [3:0] RST_AXES  = 4'h7;
  localparam logic [6:0] RST_EV_EN = 7'h00;

  typedef enum logic [2:0] {
    TS_IDLE, TS_TAP1, TS_GAP, TS_WIN, TS_TAP2, TS_LOW
  } tle_tap_t;

  typedef struct packed {
    logic [7:0]  tap_level;
    logic [7:0]  max_duration;
    logic [7:0]  gap;
    logic [7:0]  win;
    logic [3:0]  axes;
    logic [6:0]  ev_en;
    logic [4:0]  ev_src;
    logic [2:0]  first_axis;
    logic        auto_sleep_flag;
    logic [7:0]  act_lvl;
    logic [7:0]  inact_lvl;
    logic [7:0]  ff_lvl;
    logic [7:0]  decim;
    logic [7:0]  dcnt;
    logic        odr;
    tle_tap_t    tst;
    logic [7:0]  tcnt;
    logic [2:0]  tax_pend;
    logic        act_armed;
    logic        inact_armed;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tle_st_t;

endpackage : tle_pkg

// >>> testbench/tle_host_model.sv
`timescale 1ns/1ps
// host side: the apb master that software uses to reach the settings
module tle_host_model
(
  input  wire logic        clock,
  output logic      [7:0]  paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // idle bus from time zero so nothing is requested during reset
  initial
  begin
    paddr   = 8'h00;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h0000_0000;
  end

  // one transfer; the request stands until pready is seen at an edge,
  // and a read of event source is how software acknowledges events
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : tle_host_model

// >>> testbench/tap_and_link_event_logic_tb.sv
`timescale 1ns/1ps
module tap_and_link_event_logic_tb;
  localparam logic [31:0] SGL = 32'h0000_0001 << tle_pkg::EV_SINGLE;
  localparam logic [31:0] DBL = 32'h0000_0001 << tle_pkg::EV_DOUBLE;
  localparam logic [31:0] ACT = 32'h0000_0001 << tle_pkg::EV_ACT;
  localparam logic [31:0] INA = 32'h0000_0001 << tle_pkg::EV_INACT;
  localparam logic [31:0] SLP = 32'h0000_0001 << tle_pkg::FA_SLEEP;
  localparam logic [15:0] HI  = 16'h0400;
  localparam logic [31:0] Z32 = 32'h0000_0000;

  logic        clock;
  logic        srst;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        smp_valid;
  logic [15:0] smp_x;
  logic [15:0] smp_y;
  logic [15:0] smp_z;
  logic        odr_strobe;
  logic        auto_sleep;
  int          mismatches;
  int          total_checks;
  int          cycles;
  int          odr_cnt;

  tle_tap_link #(.LVL_SHIFT(4)) dut (
    .clock(clock), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .smp_valid(smp_valid), .smp_x(smp_x), .smp_y(smp_y),
    .smp_z(smp_z), .odr_strobe(odr_strobe), .auto_sleep(auto_sleep));

  tle_host_model u_host (
    .clock(clock), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // free running clock, 20 ns period
  always #10 clock = ~clock;

  // cycle ceiling and decimated strobe count
  always @(posedge clock)
  begin
    cycles++;
    if (odr_strobe === 1'b1) odr_cnt++;
    if (cycles == 40000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    u_host.xfer(a, 1'b1, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    u_host.xfer(a, 1'b0, Z32, q, e);
    check(q, x);
  endtask : rd

  // n raw samples, one strobe each with two quiet cycles between
  task automatic smp(input logic [15:0] x, input logic [15:0] y, int n);
    repeat (n)
    begin
      @(posedge clock);
      smp_valid <= 1'b1;
      smp_x     <= x;
      smp_y     <= y;
      smp_z     <= y; // z mirrors y, so only axis select can split them
      @(posedge clock);
      smp_valid <= 1'b0;
      @(posedge clock);
    end
  endtask : smp

  // reset values, unmapped access, read-only place, plain write
  task automatic s_reset();
    logic [31:0] q;
    logic        e;
    rd(tle_pkg::OFF_TAP_LEVEL, {24'h00_0000, tle_pkg::RST_LEVEL});
    rd(tle_pkg::OFF_TAP_AXES, {28'h000_0000, tle_pkg::RST_AXES});
    rd(tle_pkg::OFF_EV_EN, {25'h000_0000, tle_pkg::RST_EV_EN});
    rd(tle_pkg::OFF_EV_SRC, Z32);
    u_host.xfer(8'h40, 1'b0, Z32, q, e);
    check({31'h0000_0000, e}, 32'h0000_0001);
    check(q, Z32);
    wr(tle_pkg::OFF_FIRST, 32'h0000_0007);
    rd(tle_pkg::OFF_FIRST, Z32);
    wr(tle_pkg::OFF_MAX_DURATION, 32'h0000_00A5);
    rd(tle_pkg::OFF_MAX_DURATION, 32'h0000_00A5);
  endtask : s_reset

  // decim 2 gives one strobe per three samples
  task automatic s_decim();
    wr(tle_pkg::OFF_DECIM, 32'h0000_0002);
    odr_cnt = 0;
    smp(16'h0000, 16'h0000, 6);
    // one more edge so the counter has taken the last strobe
    @(posedge clock);
    check(odr_cnt, 32'h0000_0002);
  endtask : s_decim

  // single tap at the duration boundary, then one sample too long
  task automatic s_single();
    wr(tle_pkg::OFF_TAP_LEVEL, 32'h0000_0010);
    wr(tle_pkg::OFF_MAX_DURATION, 32'h0000_0003);
    wr(tle_pkg::OFF_TAP_AXES, 32'h0000_0001);
    wr(tle_pkg::OFF_EV_EN, SGL);
    smp(HI, 16'h0000, 3);
    smp(16'h0000, 16'h0000, 1);
    rd(tle_pkg::OFF_EV_SRC, SGL);
    rd(tle_pkg::OFF_FIRST, 32'h0000_0001);
    rd(tle_pkg::OFF_EV_SRC, Z32);
    rd(tle_pkg::OFF_FIRST, 32'h0000_0001);
    smp(HI, 16'h0000, 4);
    smp(16'h0000, 16'h0000, 2);
    rd(tle_pkg::OFF_EV_SRC, Z32);
    wr(tle_pkg::OFF_EV_EN, Z32);
    smp(HI, 16'h0000, 1);
    smp(16'h0000, 16'h0000, 2);
    rd(tle_pkg::OFF_EV_SRC, Z32);
  endtask : s_single

  // only selected axes take part
  task automatic s_axes();
    wr(tle_pkg::OFF_EV_EN, SGL);
    wr(tle_pkg::OFF_TAP_AXES, 32'h0000_0002);
    smp(HI, 16'h0000, 1);
    smp(16'h0000, 16'h0000, 2);
    rd(tle_pkg::OFF_EV_SRC, Z32);
    smp(16'h0000, HI, 1);
    smp(16'h0000, 16'h0000, 2);
    rd(tle_pkg::OFF_EV_SRC, SGL);
    rd(tle_pkg::OFF_FIRST, 32'h0000_0002);
    wr(tle_pkg::OFF_TAP_AXES, 32'h0000_0004);
    smp(16'h0000, HI, 1);
    smp(16'h0000, 16'h0000, 2);
    rd(tle_pkg::OFF_EV_SRC, SGL);
    rd(tle_pkg::OFF_FIRST, 32'h0000_0004);
  endtask : s_axes

  // valid double tap; single held back until the double settles
  task automatic s_double();
    wr(tle_pkg::OFF_TAP_AXES, 32'h0000_0001);
    wr(tle_pkg::OFF_TAP_GAP, 32'h0000_0002);
    wr(tle_pkg::OFF_TAP_WIN, 32'h0000_0004);
    wr(tle_pkg::OFF_EV_EN, SGL | DBL);
    smp(HI, 16'h0000, 1);
    smp(16'h0000, 16'h0000, 1);
    rd(tle_pkg::OFF_EV_SRC, Z32);
    // two gap samples, then window index 0 stays low
    smp(16'h0000, 16'h0000, 3);
    smp(HI, 16'h0000, 1);
    smp(16'h0000, 16'h0000, 8);
    rd(tle_pkg::OFF_EV_SRC, SGL | DBL);
    rd(tle_pkg::OFF_FIRST, 32'h0000_0001);
  endtask : s_double

  // spike in gap, over-long second tap, zero gap: single only; gap and window of 0x11: double
  task automatic s_cancel();
    wr(tle_pkg::OFF_TAP_AXES, 32'h0000_0009);
    smp(HI, 16'h0000, 1);
    smp(16'h0000, 16'h0000, 1);
    smp(HI, 16'h0000, 1);
    smp(16'h0000, 16'h0000, 10);
    rd(tle_pkg::OFF_EV_SRC, SGL);
    wr(tle_pkg::OFF_TAP_AXES, 32'h0000_0001);
    smp(HI, 16'h0000, 1);
    smp(16'h0000, 16'h0000, 4);
    smp(HI, 16'h0000, 5);
    smp(16'h0000, 16'h0000, 10);
    rd(tle_pkg::OFF_EV_SRC, SGL);
    // second tap at window open, then a window that expires unused
    smp(HI, 16'h0000, 1);
    smp(16'h0000, 16'h0000, 3);
    smp(HI, 16'h0000, 1);
    smp(16'h0000, 16'h0000, 2);
    rd(tle_pkg::OFF_EV_SRC, SGL);
    smp(HI, 16'h0000, 1);
    smp(16'h0000, 16'h0000, 8);
    rd(tle_pkg::OFF_EV_SRC, SGL);
    // tuning start point: gap and window both above 0x10
    wr(tle_pkg::OFF_TAP_GAP, 32'h0000_0011);
    wr(tle_pkg::OFF_TAP_WIN, 32'h0000_0011);
    smp(HI, 16'h0000, 1);
    smp(16'h0000, 16'h0000, 19);
    smp(HI, 16'h0000, 1);
    smp(16'h0000, 16'h0000, 2);
    rd(tle_pkg::OFF_EV_SRC, SGL | DBL);
    wr(tle_pkg::OFF_TAP_GAP, Z32);
    smp(HI, 16'h0000, 1);
    smp(16'h0000, 16'h0000, 2);
    rd(tle_pkg::OFF_EV_SRC, SGL);
  endtask : s_cancel

  // link: inactivity first, sleep held off by an uncleared activity
  task automatic s_link();
    wr(tle_pkg::OFF_ACT_LVL, 32'h0000_0010);
    wr(tle_pkg::OFF_INACT_LVL, 32'h0000_0008);
    wr(tle_pkg::OFF_EV_EN, ACT | INA | 32'h0000_0060);
    smp(HI, 16'h0000, 1);
    rd(tle_pkg::OFF_EV_SRC, Z32);
    smp(16'h0000, 16'h0000, 1);
    check({31'h0000_0000, auto_sleep}, 32'h0000_0001);
    rd(tle_pkg::OFF_FIRST, SLP | 32'h0000_0001);
    rd(tle_pkg::OFF_EV_SRC, INA);
    smp(HI, 16'h0000, 1);
    check({31'h0000_0000, auto_sleep}, Z32);
    smp(16'h0000, 16'h0000, 1);
    check({31'h0000_0000, auto_sleep}, Z32);
    rd(tle_pkg::OFF_EV_SRC, ACT | INA);
  endtask : s_link

  // reset for six cycles, then every scenario in turn
  initial
  begin
    clock        = 1'b0;
    srst         = 1'b1;
    smp_valid    = 1'b0;
    smp_x        = 16'h0000;
    smp_y        = 16'h0000;
    smp_z        = 16'h0000;
    mismatches   = 0;
    total_checks = 0;
    cycles       = 0;
    odr_cnt      = 0;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    s_reset();
    s_decim();
    s_single();
    s_axes();
    s_double();
    s_cancel();
    s_link();
    print_verdict();
  end
endmodule : tap_and_link_event_logic_tb
